// ==== inc/emss_regs.vh ====
// constants for the external memory strobe and select block
`ifndef EMSS_REGS_VH
`define EMSS_REGS_VH
`define EMSS_ADDR_W       24
`define EMSS_DATA_W       16
`define EMSS_FIFO_DEPTH   16
`define EMSS_PUDR_CTRL_BIT 0
`define EMSS_PUR_PS_BIT   8
`define EMSS_PUR_DS_BIT   9
`define EMSS_PUR_RST      16'hffff
`define EMSS_DRV_RST      1'b0
`define EMSS_STROBE_NS    80
`define EMSS_CLK_NS       40
`define EMSS_STROBE_CYC   ((`EMSS_STROBE_NS + `EMSS_CLK_NS - 1) / `EMSS_CLK_NS)
`endif

// ==== logic/emss_fifo.v ====
// request fifo built from flip-flops
`timescale 1ns/100ps
`default_nettype none
module emss_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             clk_en,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // emss_fifo
`default_nettype wire

// ==== logic/emss_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module emss_sync #(
  parameter WIDTH = 18
) (
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // emss_sync
`default_nettype wire

// ==== logic/emss_top.v ====
// external memory strobe, select and data bus pin logic
// Overview of operation
// R1: write strobe low only during an external write cycle, high otherwise.
// R2: while write strobe is low, all sixteen data lines drive write data.
// R3: external memory captures data on the rising write strobe.
// R4: address, space selects and chip selects stay valid throughout the strobe.
// R5: write strobe floats when bus idle unless bus drive hold is set.
// R6: software should set bus drive hold to one to keep lines driven.
// R7: control pins pull-up disable bit turns off write strobe pull-up.
// R8: select line zero resets to the program space select role.
// R9: program space select low for every external program access.
// R10: select line zero floats when bus idle unless bus drive hold set.
// R11: select line one resets to the data space select role.
// R12: data space select low for every external data access.
// R13: select line one floats when bus idle unless bus drive hold set.
// R14: port d line eight programmable in or out; pull-up bit 8 clears pull-up.
// R15: pull-up bit 9 clear turns off data space select pin pull-up.
// R16: read strobe low floats data bus; read data latched at strobe rise.
// R17: per-pin function select between memory select and port d output.
// R18: write and read strobes never low in the same cycle.
`include "emss_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module emss_top (
  input  wire                    core_clk,
  input  wire                    nrst,
  input  wire                    clk_en,
  // request side
  input  wire                    req_valid,
  output wire                    req_ready,
  input  wire                    req_write,
  input  wire                    req_program,
  input  wire [`EMSS_ADDR_W-1:0] req_addr,
  input  wire [`EMSS_DATA_W-1:0] req_wdata,
  output reg                     rd_valid,
  output reg  [`EMSS_DATA_W-1:0] rd_data,
  output wire                    busy,
  // configuration
  input  wire                    bus_drive_hold,
  input  wire                    pudr_ctrl,
  input  wire [15:0]             port_d_pullup_enable,
  input  wire                    sel_zero_gpio,
  input  wire                    sel_one_gpio,
  input  wire [1:0]              port_d_dir,
  input  wire [1:0]              port_d_out,
  output wire [1:0]              port_d_in,
  // pins
  output reg  [`EMSS_ADDR_W-1:0] addr_pin,
  input  wire [`EMSS_DATA_W-1:0] data_pin_in,
  output reg  [`EMSS_DATA_W-1:0] data_pin_out,
  output wire [`EMSS_DATA_W-1:0] data_pin_oe_n,
  output wire                    write_strobe_n,
  output wire                    write_strobe_oe_n,
  output wire                    write_strobe_pullup,
  output wire                    read_strobe_n,
  output wire                    read_strobe_oe_n,
  input  wire                    select_line_zero_in,
  output wire                    select_line_zero,
  output wire                    select_line_zero_oe_n,
  output wire                    select_line_zero_pullup,
  input  wire                    select_line_one_in,
  output wire                    select_line_one,
  output wire                    select_line_one_oe_n,
  output wire                    select_line_one_pullup
);
  localparam FW = `EMSS_ADDR_W + `EMSS_DATA_W + 2;
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_WRITE = 4'h2;
  localparam [3:0] ST_READ  = 4'h4;
  localparam [3:0] ST_END   = 4'h8;
  localparam integer STROBE_CYC_I = `EMSS_STROBE_CYC;
  localparam [3:0]   STROBE_CYC   = STROBE_CYC_I[3:0];

  reg  [3:0]              state;
  reg  [3:0]              next_state;
  reg  [3:0]              hold_cnt;
  reg                     wr_n;
  reg                     rd_n;
  reg                     ps_n;
  reg                     ds_n;
  reg                     bus_active;
  reg                     rd_pending;
  wire                    f_valid;
  wire                    f_ready;
  wire [FW-1:0]           f_data;
  wire [`EMSS_DATA_W+1:0] pins_sync;
  wire                    take;

  emss_fifo #(
    .WIDTH (FW),
    .DEPTH (`EMSS_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_program, req_addr, req_wdata}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // pins arrive from outside: synchronise before use
  emss_sync #(
    .WIDTH (`EMSS_DATA_W + 2)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .async_in ({select_line_one_in, select_line_zero_in, data_pin_in}),
    .sync_out (pins_sync)
  );

  // fifo pops only from idle, so a request waits while a cycle runs
  assign take    = (state == ST_IDLE) & f_valid;
  assign f_ready = take;
  assign busy    = (state != ST_IDLE) | f_valid;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = f_data[FW-1] ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (hold_cnt == 4'h0) begin
          next_state = ST_END;
        end
      end
      ST_READ: begin
        if (hold_cnt == 4'h0) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= ST_IDLE;
      hold_cnt     <= 4'h0;
      wr_n         <= 1'b1;
      rd_n         <= 1'b1;
      ps_n         <= 1'b1;
      ds_n         <= 1'b1;
      bus_active   <= 1'b0;
      rd_pending   <= 1'b0;
      addr_pin     <= {`EMSS_ADDR_W{1'b0}};
      data_pin_out <= {`EMSS_DATA_W{1'b0}};
      rd_valid     <= 1'b0;
      rd_data      <= {`EMSS_DATA_W{1'b0}};
    end else if (clk_en) begin
      state    <= next_state;
      rd_valid <= 1'b0;
      if (take) begin
        // address and selects set with the strobe, held until one cycle after it rises
        addr_pin     <= f_data[`EMSS_DATA_W +: `EMSS_ADDR_W]; // [R4]
        data_pin_out <= f_data[`EMSS_DATA_W-1:0];
        ps_n         <= ~f_data[FW-2]; // [R9]
        ds_n         <= f_data[FW-2]; // [R12]
        wr_n         <= ~f_data[FW-1]; // [R1] [R18]
        rd_n         <= f_data[FW-1]; // [R16] [R18]
        bus_active   <= 1'b1;
        rd_pending   <= ~f_data[FW-1];
        hold_cnt     <= STROBE_CYC - 4'h1;
      end else if ((state == ST_WRITE) | (state == ST_READ)) begin
        if (hold_cnt == 4'h0) begin
          wr_n <= 1'b1; // [R1]
          rd_n <= 1'b1; // [R16]
        end else begin
          hold_cnt <= hold_cnt - 4'h1;
        end
      end else if (state == ST_END) begin
        // one cycle of hold after strobe rise so the memory captures data
        ps_n       <= 1'b1; // [R4] [R9] [R12]
        ds_n       <= 1'b1;
        bus_active <= 1'b0;
        rd_pending <= 1'b0;
        // the pin synchroniser lags two cycles, so this word was sampled while the strobe was low
        if (rd_pending) begin
          rd_data  <= pins_sync[`EMSS_DATA_W-1:0]; // [R16]
          rd_valid <= 1'b1;
        end
      end
    end
  end

  // data lines drive only while write strobe is low
  assign data_pin_oe_n = {`EMSS_DATA_W{wr_n}}; // [R2] [R16]

  // strobes float on an idle bus unless hold is set; reset value leaves them floating
  assign write_strobe_n    = wr_n;
  assign write_strobe_oe_n = ~(bus_active | bus_drive_hold); // [R5]
  assign read_strobe_n     = rd_n;
  assign read_strobe_oe_n  = ~(bus_active | bus_drive_hold);
  assign write_strobe_pullup = ~pudr_ctrl; // [R7]

  // select pins: memory role at reset when gpio select inputs are low
  wire [1:0] pin_gpio;
  wire [1:0] pin_mem_n;
  wire [1:0] pin_level;
  wire [1:0] pin_oe_n;
  wire       mem_oe_n;
  assign pin_gpio  = {sel_one_gpio, sel_zero_gpio};
  assign pin_mem_n = {ds_n, ps_n}; // [R8] [R11]
  assign mem_oe_n  = ~(bus_active | bus_drive_hold); // [R10] [R13]
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sel_pin
      assign pin_level[g] = pin_gpio[g] ? port_d_out[g] : pin_mem_n[g]; // [R17]
      assign pin_oe_n[g]  = pin_gpio[g] ? ~port_d_dir[g] : mem_oe_n; // [R10] [R13] [R14]
    end
  endgenerate
  assign select_line_zero        = pin_level[0]; // [R9]
  assign select_line_zero_oe_n   = pin_oe_n[0];
  assign select_line_zero_pullup = port_d_pullup_enable[`EMSS_PUR_PS_BIT]; // [R14]
  assign select_line_one         = pin_level[1]; // [R12]
  assign select_line_one_oe_n    = pin_oe_n[1];
  assign select_line_one_pullup  = port_d_pullup_enable[`EMSS_PUR_DS_BIT]; // [R15]
  assign port_d_in = pins_sync[`EMSS_DATA_W +: 2]; // [R14]
endmodule // emss_top
`default_nettype wire

// ==== verification/emss_properties.sv ====
// assertions on the strobe, select and data pins
`timescale 1ns/100ps
`default_nettype none
module emss_properties (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        busy,
  input wire logic        bus_drive_hold,
  input wire logic        pudr_ctrl,
  input wire logic [15:0] port_d_pullup_enable,
  input wire logic        sel_zero_gpio,
  input wire logic        sel_one_gpio,
  input wire logic [15:0] data_pin_oe_n,
  input wire logic [23:0] addr_pin,
  input wire logic        write_strobe_n,
  input wire logic        write_strobe_oe_n,
  input wire logic        write_strobe_pullup,
  input wire logic        read_strobe_n,
  input wire logic        rd_valid,
  input wire logic        select_line_zero,
  input wire logic        select_line_zero_oe_n,
  input wire logic        select_line_zero_pullup,
  input wire logic        select_line_one,
  input wire logic        select_line_one_oe_n,
  input wire logic        select_line_one_pullup
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence strobe_pulse;
    !write_strobe_n [*2] ##1 write_strobe_n;
  endsequence
  // three quiet cycles so the end of a cycle has settled
  sequence bus_idle;
    (!busy && !bus_drive_hold) [*3];
  endsequence
  strobe_width_a: assert property ($fell(write_strobe_n) |-> strobe_pulse)
    else $error("write strobe width wrong");
  strobe_excl_a: assert property (!(!write_strobe_n && !read_strobe_n))
    else $error("both strobes low");
  write_drive_a: assert property (!write_strobe_n |-> data_pin_oe_n == 16'h0000)
    else $error("data bus not driven in write");
  read_float_a: assert property (!read_strobe_n |-> data_pin_oe_n == 16'hffff)
    else $error("data bus driven in read");
  read_latch_a: assert property ($rose(read_strobe_n) |=> rd_valid)
    else $error("read data not taken");
  addr_hold_a: assert property (!write_strobe_n && !$past(write_strobe_n) |->
    $stable(addr_pin) && $stable(select_line_zero) && $stable(select_line_one)) else $error("qualified lines moved");
  space_sel_a: assert property (!write_strobe_n && !sel_zero_gpio && !sel_one_gpio |->
    select_line_zero != select_line_one) else $error("space selects not exclusive");
  idle_float_a: assert property (bus_idle |-> write_strobe_oe_n && (sel_zero_gpio || select_line_zero_oe_n)
    && (sel_one_gpio || select_line_one_oe_n)) else $error("idle bus still driven");
  hold_drive_a: assert property (bus_drive_hold [*2] ##0 !sel_zero_gpio |->
    !write_strobe_oe_n && !select_line_zero_oe_n) else $error("held bus not driven");
  pullup_ctrl_a: assert property (write_strobe_pullup == !pudr_ctrl
    && select_line_zero_pullup == port_d_pullup_enable[8] && select_line_one_pullup == port_d_pullup_enable[9])
    else $error("pull-up control wrong");
endmodule // emss_properties
bind emss_top emss_properties u_props (.core_clk(core_clk), .nrst(nrst), .busy(busy), .bus_drive_hold(bus_drive_hold),
  .pudr_ctrl(pudr_ctrl), .port_d_pullup_enable(port_d_pullup_enable), .sel_zero_gpio(sel_zero_gpio),
  .sel_one_gpio(sel_one_gpio), .data_pin_oe_n(data_pin_oe_n), .addr_pin(addr_pin), .write_strobe_n(write_strobe_n),
  .write_strobe_oe_n(write_strobe_oe_n), .write_strobe_pullup(write_strobe_pullup), .read_strobe_n(read_strobe_n),
  .rd_valid(rd_valid), .select_line_zero(select_line_zero), .select_line_zero_oe_n(select_line_zero_oe_n),
  .select_line_zero_pullup(select_line_zero_pullup), .select_line_one(select_line_one),
  .select_line_one_oe_n(select_line_one_oe_n), .select_line_one_pullup(select_line_one_pullup));
`default_nettype wire

// ==== verification/emss_sram_model.sv ====
// static ram on the far side of the pins
`timescale 1ns/100ps
`default_nettype none
module emss_sram_model (
  input  wire logic        core_clk,
  input  wire logic [23:0] addr_pin,
  input  wire logic [15:0] data_pin_out,
  input  wire logic [15:0] data_pin_oe_n,
  input  wire logic        write_level,
  input  wire logic        read_level,
  input  wire logic        program_sel_n,
  input  wire logic        data_sel_n,
  output logic      [15:0] data_bus
);
  logic [15:0] mem [0:31];
  logic [15:0] last = 16'h0000;
  wire  [4:0]  idx  = {program_sel_n, addr_pin[3:0]};
  wire         sel  = !(program_sel_n && data_sel_n);
  // sampled mid-cycle, so the word kept is the one present as the strobe rises
  always @(negedge core_clk) begin
    if (!write_level && sel) mem[idx] <= data_pin_out;
    if (!read_level && sel) last <= mem[idx];
  end
  always @* begin
    if (data_pin_oe_n == 16'h0000) data_bus = data_pin_out;
    else if (!read_level && sel) data_bus = mem[idx];
    else data_bus = ~last; // released bus never holds its last word
  end
endmodule // emss_sram_model
`default_nettype wire

// ==== verification/emss_top_tb.sv ====
// bench for the strobe, select and data pin block
`timescale 1ns/100ps
`default_nettype none
module emss_top_tb;
  logic        core_clk = 1'b0;
  logic        nrst, req_valid, req_write, req_program, bus_drive_hold, pudr_ctrl, sel_zero_gpio, sel_one_gpio;
  logic [1:0]  port_d_dir, port_d_out;
  logic [15:0] port_d_pullup_enable, req_wdata;
  logic [23:0] req_addr;
  wire         clk_en = 1'b1;
  wire         req_ready, rd_valid, busy, write_strobe_n, write_strobe_oe_n, write_strobe_pullup;
  wire         read_strobe_n, read_strobe_oe_n, select_line_zero, select_line_zero_oe_n, select_line_zero_pullup;
  wire         select_line_one, select_line_one_oe_n, select_line_one_pullup, select_line_zero_in, select_line_one_in;
  wire [1:0]   port_d_in;
  wire [15:0]  rd_data, data_pin_in, data_pin_out, data_pin_oe_n;
  wire [23:0]  addr_pin;
  wire         write_level = write_strobe_oe_n ? 1'b1 : write_strobe_n;
  wire         read_level  = read_strobe_oe_n ? 1'b1 : read_strobe_n;
  assign select_line_zero_in = select_line_zero_oe_n ? (select_line_zero_pullup | !select_line_zero) : select_line_zero;
  assign select_line_one_in  = select_line_one_oe_n ? (select_line_one_pullup | !select_line_one) : select_line_one;
  int          mismatches = 0;
  int          tests_run = 0;
  logic        saw_full;
  emss_top dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_program(req_program), .req_addr(req_addr), .req_wdata(req_wdata),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .bus_drive_hold(bus_drive_hold), .pudr_ctrl(pudr_ctrl),
    .port_d_pullup_enable(port_d_pullup_enable), .sel_zero_gpio(sel_zero_gpio), .sel_one_gpio(sel_one_gpio),
    .port_d_dir(port_d_dir), .port_d_out(port_d_out), .port_d_in(port_d_in), .addr_pin(addr_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
    .write_strobe_n(write_strobe_n), .write_strobe_oe_n(write_strobe_oe_n), .write_strobe_pullup(write_strobe_pullup),
    .read_strobe_n(read_strobe_n), .read_strobe_oe_n(read_strobe_oe_n), .select_line_zero_in(select_line_zero_in),
    .select_line_zero(select_line_zero), .select_line_zero_oe_n(select_line_zero_oe_n),
    .select_line_zero_pullup(select_line_zero_pullup), .select_line_one_in(select_line_one_in),
    .select_line_one(select_line_one), .select_line_one_oe_n(select_line_one_oe_n),
    .select_line_one_pullup(select_line_one_pullup));
  emss_sram_model mem_model (.core_clk, .addr_pin, .data_pin_out, .data_pin_oe_n, .write_level, .read_level,
    .program_sel_n(select_line_zero_in), .data_sel_n(select_line_one_in), .data_bus(data_pin_in));
  always #20 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // entered at a falling edge; valid stays up so pushes can run back to back
  task automatic push(input logic w, input logic p, input logic [23:0] a, input logic [15:0] d);
    {req_valid, req_write, req_program, req_addr, req_wdata} = {1'b1, w, p, a, d};
    while (req_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge core_clk);
    end
    @(negedge core_clk);
  endtask
  task automatic t_reset_state;
    check({write_strobe_n, write_strobe_oe_n, select_line_zero_oe_n, select_line_one_oe_n, data_pin_oe_n},
      20'hfffff);
  endtask
  task automatic t_pullups;
    for (int k = 0; k < 2; k++) begin
      pudr_ctrl = k[0];
      port_d_pullup_enable = k[0] ? 16'hfcff : 16'hffff;
      @(negedge core_clk);
      check({write_strobe_pullup, select_line_zero_pullup, select_line_one_pullup}, k[0] ? 3'h0 : 3'h7);
    end
    pudr_ctrl = 1'b0;
    port_d_pullup_enable = 16'hffff;
  endtask
  task automatic t_gpio;
    {sel_zero_gpio, sel_one_gpio, port_d_dir} = 4'hf;
    for (int k = 1; k < 3; k++) begin
      port_d_out = k[1:0];
      repeat (4) @(negedge core_clk);
      check({select_line_one, select_line_zero, port_d_in}, {k[1:0], k[1:0]});
    end
    port_d_dir = 2'h0;
    repeat (4) @(negedge core_clk);
    check({select_line_one_oe_n, select_line_zero_oe_n, port_d_in}, 4'hf);
    {sel_zero_gpio, sel_one_gpio} = 2'h0;
  endtask
  // twenty-four writes back to back fill the queue, then every word is read back
  task automatic t_traffic;
    saw_full = 1'b0;
    for (int i = 0; i < 24; i++) push(1'b1, i[0], {20'h5a000, i[4:1]}, 16'ha500 | i[15:0]);
    req_valid = 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
    check(saw_full, 1'b1);
    for (int i = 0; i < 24; i++) begin
      bus_drive_hold = (i >= 10);
      push(1'b0, i[0], {20'h5a000, i[4:1]}, 16'h0000);
      req_valid = 1'b0;
      for (int j = 0; j < 50 && read_strobe_n !== 1'b0; j++) @(negedge core_clk);
      check({select_line_zero, select_line_one}, {!i[0], i[0]});
      for (int j = 0; j < 50 && rd_valid !== 1'b1; j++) @(negedge core_clk);
      check(rd_data, 16'ha500 | i[15:0]);
      repeat (3) @(negedge core_clk);
    end
  endtask
  task automatic t_hold;
    repeat (3) @(negedge core_clk);
    check({write_strobe_oe_n, read_strobe_oe_n, select_line_zero_oe_n, select_line_one_oe_n, write_strobe_n},
      5'h01);
    bus_drive_hold = 1'b0;
    repeat (4) @(negedge core_clk);
    check({write_strobe_oe_n, read_strobe_oe_n, select_line_zero_oe_n, select_line_one_oe_n}, 4'hf);
  endtask
  initial begin
    {nrst, req_valid, req_write, req_program, bus_drive_hold, pudr_ctrl, sel_zero_gpio, sel_one_gpio} = 8'h00;
    {port_d_dir, port_d_out, req_addr, req_wdata} = 44'h0;
    port_d_pullup_enable = 16'hffff;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    t_reset_state();
    t_pullups();
    t_gpio();
    t_traffic();
    t_hold();
    stop_test();
  end
  initial begin
    #(40 * 5000);
    mismatches++;
    stop_test();
  end
endmodule // emss_top_tb
`default_nettype wire
